/* verilog/timer16_defines.vh */
/*
  constants of the 16-bit timer/counter: register offsets,
  field positions, reset values and mode codes.
  assumes inclusion by bare name from the design files.
*/
`ifndef TIMER16_DEFINES_VH
`define TIMER16_DEFINES_VH

// ----------------------------------------
// register offsets (2-bit address)
// ----------------------------------------
`define OFS_CONTROL      2'h0
`define OFS_COUNT_LOW    2'h1
`define OFS_COUNT_HIGH   2'h2
`define OFS_FLAGS        2'h3

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CTL_WIDE_ACCESS  7
`define CTL_TB_HIGH      6
`define CTL_PRE_HI       5
`define CTL_PRE_LO       4
`define CTL_TB_LOW       3
`define CTL_SYNC_BYPASS  2
`define CTL_CLK_SOURCE   1
`define CTL_COUNT_EN     0
`define CTL_RESET        8'h00

// ----------------------------------------
// flags register fields
// ----------------------------------------
`define FLG_OVERFLOW     0
`define FLG_IRQ_EN       1

// ----------------------------------------
// counter and timing constants
// ----------------------------------------
`define COUNT_RESET      16'h0000
`define COUNT_MAX        16'hFFFF
`define SPECIAL_EVENT    4'hB
`define INSTR_DIV_LAST   2'h3

`endif

/* verilog/input_prescaler.v */
/*
  input prescaler: divides a tick stream by 1, 2, 4 or 8.
  assumes ticks are one-cycle pulses on the same clock.
*/
module input_prescaler
(
  input  wire       i_sys_clk,
  input  wire       i_srst,
  input  wire       i_tick,
  input  wire       i_clear,
  input  wire [1:0] i_ratio,
  output wire       o_pulse
);

  // ----------------------------------------
  // divide counter
  // ----------------------------------------
  reg  [2:0] div_q;   // running count of ticks
  reg  [2:0] mask;    // bits that must be set to pass

  // mask from ratio field
  always @*
  begin
    case (i_ratio)
      2'h3:    mask = 3'h7;   // 1:8
      2'h2:    mask = 3'h3;   // 1:4
      2'h1:    mask = 3'h1;   // 1:2
      default: mask = 3'h0;   // 1:1
    endcase
  end

  // pass a tick when the masked count is full
  assign o_pulse = i_tick && ((div_q & mask) == mask);

  // count ticks; clear on request
  always @(posedge i_sys_clk)
  begin
    if (i_srst || i_clear)
      div_q <= 3'h0;
    else if (i_tick)
      div_q <= div_q + 3'h1;
  end

endmodule

/* verilog/timer16.v */
/*
  16-bit timer/counter with prescaler, buffered wide access,
  overflow flag and special event reset.
  assumes a one-cycle strobe register port, pins sampled here.
*/
// The implementer's own choices: the plain strobed port and the address map.
// Behaviour
// R1: wide access bit buffers 16-bit access
// R2: timebase bits pick counter per capture unit
// R3: prescale field divides by 1,2,4,8
// R4: sync bit chooses unsynchronised external clock
// R5: internal source ignores sync bit
// R6: source select; first falling edge arms counting
// R7: count enable starts and holds counter
// R8: timer, sync and async counter modes
// R9: oscillator enabled: pins read zero
// R10: low-byte read copies high byte into buffer
// R11: buffered high byte loads on low write
// R12: wide mode high byte only via buffer
// R13: only low-byte writes clear prescaler
// R14: counter wraps and latches overflow flag
// R15: irq only when flag and enable set
// R16: special event match resets counter
// R17: software uses synced modes for event reset
// R18: software write beats special event reset
// R19: unit two event never sets flag
// R20: software enables oscillator plus source select
// R21: synced external clock via flop chain
// R22: narrow mode high byte accessed directly
`include "timer16_defines.vh"

module timer16
(
  input  wire        i_sys_clk,
  input  wire        i_srst,
  input  wire [1:0]  i_addr,
  input  wire [7:0]  i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [7:0]  o_rdata_q,
  input  wire [1:0]  i_shared_pins,
  input  wire        i_aux_osc_clk,
  input  wire        i_aux_oscillator_enable,
  input  wire [3:0]  i_unit_one_mode_field,
  input  wire [3:0]  i_unit_two_mode_field,
  input  wire        i_unit_one_match,
  input  wire        i_unit_two_match,
  output reg  [15:0] o_count_q,
  output reg         o_unit_one_this_q,
  output reg         o_unit_two_this_q,
  output reg  [1:0]  o_pins_read_q,
  output reg         o_dir_ignored_q,
  output reg         o_irq_q
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [7:0]  ctrl_q;       // second_timer_control
  reg  [15:0] cnt_q;        // the counter itself
  reg  [7:0]  hbuf_q;       // high byte buffer
  reg         ovf_q;        // overflow_flag
  reg         irq_en_q;     // overflow_irq_enable
  reg  [1:0]  phase_q;      // instruction cycle divider
  reg  [2:0]  s1_q;         // pin sync stage 1
  reg  [2:0]  s2_q;         // pin sync stage 2
  reg  [2:0]  s3_q;         // pin sync stage 3
  reg  [2:0]  lvl_q;        // agreed pin levels
  reg         src_prev_q;   // previous external level
  reg         armed_q;      // falling edge seen

  // ----------------------------------------
  // control fields
  // ----------------------------------------
  wire        wide     = ctrl_q[`CTL_WIDE_ACCESS];
  wire        tb_hi    = ctrl_q[`CTL_TB_HIGH];
  wire        tb_lo    = ctrl_q[`CTL_TB_LOW];
  wire [1:0]  ratio    = {ctrl_q[`CTL_PRE_HI], ctrl_q[`CTL_PRE_LO]};
  wire        bypass   = ctrl_q[`CTL_SYNC_BYPASS];
  wire        ext_sel  = ctrl_q[`CTL_CLK_SOURCE];
  wire        run      = ctrl_q[`CTL_COUNT_EN];

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire wr_ctrl  = i_wr && (i_addr == `OFS_CONTROL);
  wire wr_low   = i_wr && (i_addr == `OFS_COUNT_LOW);
  wire wr_high  = i_wr && (i_addr == `OFS_COUNT_HIGH);
  wire wr_flags = i_wr && (i_addr == `OFS_FLAGS);
  wire rd_low   = i_rd && (i_addr == `OFS_COUNT_LOW);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // bit 0: shared pin with count input
  // bit 1: oscillator input pin
  // bit 2: oscillator clock
  wire [2:0] pin_raw = {i_aux_osc_clk, i_shared_pins};

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_sync
      // three flops; level moves once stage 2 and 3 agree
      always @(posedge i_sys_clk)
      begin
        if (i_srst)
        begin
          s1_q[g]  <= 1'b0;
          s2_q[g]  <= 1'b0;
          s3_q[g]  <= 1'b0;
          lvl_q[g] <= 1'b0;
        end
        else
        begin
          s1_q[g] <= pin_raw[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g])
            lvl_q[g] <= s2_q[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // external source selection
  // ----------------------------------------
  // oscillator when enabled, else count input pin
  wire ext_fast = i_aux_oscillator_enable ? s3_q[2] : s3_q[0];
  wire ext_filt = i_aux_oscillator_enable ? lvl_q[2] : lvl_q[0];

  // unsynchronised path skips the agreement filter
  wire ext_lvl  = bypass ? ext_fast : ext_filt;   // R4 R21

  wire ext_rise = ext_lvl && !src_prev_q;
  wire ext_fall = !ext_lvl && src_prev_q;

  // ----------------------------------------
  // edge tracking and arming
  // ----------------------------------------
  // rising edges count only after a falling edge
  always @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      src_prev_q <= 1'b0;
      armed_q    <= 1'b0;
    end
    else
    begin
      src_prev_q <= ext_lvl;
      if (!ext_sel || !run)
        armed_q <= 1'b0;                          // R6
      else if (ext_fall)
        armed_q <= 1'b1;                          // R6
    end
  end

  // ----------------------------------------
  // instruction cycle divider
  // ----------------------------------------
  // one tick per four core clocks
  always @(posedge i_sys_clk)
  begin
    if (i_srst)
      phase_q <= 2'h0;
    else
      phase_q <= phase_q + 2'h1;
  end

  wire int_tick = (phase_q == `INSTR_DIV_LAST);

  // ----------------------------------------
  // count tick
  // ----------------------------------------
  // internal source ignores the sync bit
  wire raw_tick = ext_sel ? (ext_rise && armed_q)   // R6 R8
                          : int_tick;               // R5 R8
  wire gate_tick = run && raw_tick;                 // R7

  wire pre_pulse;

  // prescaler clears only on low-byte writes
  input_prescaler u_pre
  (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .i_tick    (gate_tick),
    .i_clear   (wr_low),                            // R13
    .i_ratio   (ratio),                             // R3
    .o_pulse   (pre_pulse)
  );

  // ----------------------------------------
  // timebase selection
  // ----------------------------------------
  // 1x: both units; 01: unit two; 00: none
  wire one_this = tb_hi;                            // R2
  wire two_this = tb_hi || tb_lo;                   // R2

  // special event from a unit using this counter
  wire ev_one = one_this && i_unit_one_match &&
                (i_unit_one_mode_field == `SPECIAL_EVENT);
  wire ev_two = two_this && i_unit_two_match &&
                (i_unit_two_mode_field == `SPECIAL_EVENT);
  wire ev_rst = ev_one || ev_two;                   // R16

  // wrap only from an increment, never a reset or a write
  wire cnt_load = wr_low || (wr_high && !wide);
  wire wrap = pre_pulse && !ev_rst && !cnt_load &&
              (cnt_q == `COUNT_MAX);                // R14 R19

  // ----------------------------------------
  // counter
  // ----------------------------------------
  // writes first, then event reset, then count
  always @(posedge i_sys_clk)
  begin
    if (i_srst)
      cnt_q <= `COUNT_RESET;
    else if (wr_low)
    begin
      if (wide)
        cnt_q <= {hbuf_q, i_wdata};                 // R11 R18
      else
        cnt_q <= {cnt_q[15:8], i_wdata};            // R1 R18
    end
    else if (wr_high && !wide)
      cnt_q[15:8] <= i_wdata;                       // R22 R18
    else if (ev_rst)
      cnt_q <= `COUNT_RESET;                        // R16
    else if (pre_pulse)
      cnt_q <= cnt_q + 16'h0001;                    // R14
  end

  // ----------------------------------------
  // high byte buffer
  // ----------------------------------------
  // only used in wide mode
  always @(posedge i_sys_clk)
  begin
    if (i_srst)
      hbuf_q <= 8'h00;
    else if (wide && wr_high)
      hbuf_q <= i_wdata;                            // R11 R12
    else if (wide && rd_low)
      hbuf_q <= cnt_q[15:8];                        // R10
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always @(posedge i_sys_clk)
  begin
    if (i_srst)
      ctrl_q <= `CTL_RESET;
    else if (wr_ctrl)
      ctrl_q <= i_wdata;
  end

  // ----------------------------------------
  // flags register
  // ----------------------------------------
  // overflow set wins over a software clear
  always @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      ovf_q    <= 1'b0;
      irq_en_q <= 1'b0;
    end
    else
    begin
      if (wrap)
        ovf_q <= 1'b1;                              // R14
      else if (wr_flags)
        ovf_q <= i_wdata[`FLG_OVERFLOW];
      if (wr_flags)
        irq_en_q <= i_wdata[`FLG_IRQ_EN];
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // data stand in the cycle after the strobe
  always @(posedge i_sys_clk)
  begin
    if (i_srst)
      o_rdata_q <= 8'h00;
    else if (i_rd)
    begin
      case (i_addr)
        `OFS_CONTROL:
          o_rdata_q <= ctrl_q;
        `OFS_COUNT_LOW:
          o_rdata_q <= cnt_q[7:0];
        `OFS_COUNT_HIGH:
        begin
          if (wide)
            o_rdata_q <= hbuf_q;                    // R12
          else
            o_rdata_q <= cnt_q[15:8];               // R22
        end
        `OFS_FLAGS:
          o_rdata_q <= {6'h00, irq_en_q, ovf_q};
        default:
          o_rdata_q <= 8'h00;
      endcase
    end
    else
      o_rdata_q <= 8'h00;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // registered views for the capture units and pins
  always @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      o_count_q         <= `COUNT_RESET;
      o_unit_one_this_q <= 1'b0;
      o_unit_two_this_q <= 1'b0;
      o_pins_read_q     <= 2'h0;
      o_dir_ignored_q   <= 1'b0;
      o_irq_q           <= 1'b0;
    end
    else
    begin
      o_count_q         <= cnt_q;
      o_unit_one_this_q <= one_this;                // R2
      o_unit_two_this_q <= two_this;                // R2
      // oscillator owns both pins: read zero
      if (i_aux_oscillator_enable)
        o_pins_read_q <= 2'h0;                      // R9
      else
        o_pins_read_q <= lvl_q[1:0];
      o_dir_ignored_q   <= i_aux_oscillator_enable; // R9
      o_irq_q           <= ovf_q && irq_en_q;       // R15
    end
  end

endmodule

/* sim/timer16_props.sv */
/*
  port checker of timer16 with shadows of control and irq enable.
  assumes a bind onto timer16, one clock, synchronous reset.
*/
`include "timer16_defines.vh"
module timer16_props
(
  input wire        i_sys_clk,
  input wire        i_srst,
  input wire [1:0]  i_addr,
  input wire [7:0]  i_wdata,
  input wire        i_wr,
  input wire        i_aux_oscillator_enable,
  input wire [3:0]  i_unit_one_mode_field,
  input wire [3:0]  i_unit_two_mode_field,
  input wire        i_unit_one_match,
  input wire        i_unit_two_match,
  input wire [15:0] o_count_q,
  input wire        o_unit_one_this_q,
  input wire        o_unit_two_this_q,
  input wire [1:0]  o_pins_read_q,
  input wire        o_dir_ignored_q,
  input wire        o_irq_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_srst);
  // ------
  // shadows
  // ------
  logic [7:0] ctl_q;  // control as written
  logic       ie_q;   // irq enable as written
  wire        cnt_wr = i_wr && (i_addr == `OFS_COUNT_LOW || i_addr == `OFS_COUNT_HIGH);
  wire        quiet  = !cnt_wr && !i_unit_one_match && !i_unit_two_match;
  wire        ev     = (i_unit_one_match && i_unit_one_mode_field == `SPECIAL_EVENT && ctl_q[6])
    || (i_unit_two_match && i_unit_two_mode_field == `SPECIAL_EVENT && (ctl_q[6] || ctl_q[3]));
  always @(posedge i_sys_clk)
    ctl_q <= i_srst ? `CTL_RESET : (i_wr && i_addr == `OFS_CONTROL) ? i_wdata : ctl_q;
  always @(posedge i_sys_clk)
    ie_q <= i_srst ? 1'b0 : (i_wr && i_addr == `OFS_FLAGS) ? i_wdata[`FLG_IRQ_EN] : ie_q;
  stall_hold_a: assert property (!ctl_q[`CTL_COUNT_EN] && quiet
    |=> ##1 $stable(o_count_q)) else $error("count moved while stopped");
  wrap_flag_a: assert property ($past(o_count_q) == `COUNT_MAX && o_count_q == `COUNT_RESET
    && $past(quiet, 2) && ie_q && $past(ie_q) |-> o_irq_q) else $error("wrap without irq");
  irq_mask_a: assert property (!$past(ie_q) |-> !o_irq_q) else $error("irq while masked");
  event_reset_a: assert property (ev && !cnt_wr |-> ##2 o_count_q == `COUNT_RESET)
    else $error("event did not clear count");
  write_wins_a: assert property (i_wr && i_addr == `OFS_COUNT_LOW
    |-> ##2 o_count_q[7:0] == $past(i_wdata, 2)) else $error("low write lost");
  unit_one_sel_a: assert property ($stable(ctl_q)
    |-> o_unit_one_this_q == ctl_q[`CTL_TB_HIGH]) else $error("unit one timebase wrong");
  unit_two_sel_a: assert property ($stable(ctl_q)
    |-> o_unit_two_this_q == (ctl_q[`CTL_TB_HIGH] | ctl_q[`CTL_TB_LOW])) else $error("unit two timebase wrong");
  osc_pins_a: assert property (!$past(i_srst) && $past(i_aux_oscillator_enable)
    && $past(i_aux_oscillator_enable, 2) |-> o_pins_read_q == 2'b00 && o_dir_ignored_q)
    else $error("pins live under oscillator");
  cover property (ev && cnt_wr);
  cover property (ev && !cnt_wr);
  cover property ($rose(o_irq_q));
endmodule

bind timer16 timer16_props u_props
(
  .i_sys_clk, .i_srst, .i_addr, .i_wdata, .i_wr, .i_aux_oscillator_enable,
  .i_unit_one_mode_field, .i_unit_two_mode_field, .i_unit_one_match, .i_unit_two_match,
  .o_count_q, .o_unit_one_this_q, .o_unit_two_this_q, .o_pins_read_q, .o_dir_ignored_q, .o_irq_q
);

/* sim/capture_model.sv */
/*
  far side model: two capture units, the count pin, the oscillator.
  assumes one-cycle fire requests from the bench on the system clock.
*/
module capture_model
(
  input  wire       i_clk,
  input  wire       i_run,
  input  wire       i_osc_run,
  input  wire [3:0] i_mode,
  input  wire       i_fire_one,
  input  wire       i_fire_two,
  output reg        o_pin,
  output reg        o_osc,
  output wire [3:0] o_mode,
  output reg        o_match_one,
  output reg        o_match_two
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [2:0] div_q;  // phase of both source clocks
  assign o_mode = i_mode;  // same mode on both units
  initial
  begin
    {o_pin, o_osc, o_match_one, o_match_two, div_q} = 7'h00;
  end
  // sources stand still unless asked to run, edges land off the clock
  always @(posedge i_clk)
  begin
    div_q <= div_q + 3'h1;
    o_pin <= #7 o_pin ^ (i_run && div_q == 3'h7);
    o_osc <= #7 o_osc ^ (i_osc_run && div_q[1:0] == 2'h3);
    o_match_one <= i_fire_one;  // one-cycle match
    o_match_two <= i_fire_two;
  end
endmodule

/* sim/timer16_tb.sv */
/*
  self-checking bench of timer16: a row table, then hand tests.
  assumes capture_model on the far side and the bound checker.
*/
`include "timer16_defines.vh"
module timer16_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_sys_clk, i_srst, i_wr, i_rd, run, osc_run, osc_en, f1, f2;
  logic [1:0]  i_addr;
  logic [7:0]  i_wdata;
  logic [3:0]  mode;
  wire  [7:0]  o_rdata_q;
  wire  [15:0] o_count_q;
  wire  [3:0]  mode_o;
  wire  [1:0]  o_pins_read_q;
  wire         pin, osc, m1, m2, o_unit_one_this_q, o_unit_two_this_q, o_dir_ignored_q, o_irq_q;
  int          n_errors, n_compared;
  logic [7:0]  rc [6] = '{8'h01, 8'h19, 8'h61, 8'h79, 8'h00, 8'h05};  // control per row
  int          re [6] = '{10, 10, 10, 10, 0, 10};  // increments per row
  logic [7:0]  xc [3] = '{8'h03, 8'h07, 8'h03};  // external source rows
  int          xe [3] = '{10, 10, 20};  // rising edges per row
  timer16 uut
  (
    .i_sys_clk, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata_q, .i_shared_pins({osc, pin}),
    .i_aux_osc_clk(osc), .i_aux_oscillator_enable(osc_en), .i_unit_one_mode_field(mode_o),
    .i_unit_two_mode_field(mode_o), .i_unit_one_match(m1), .i_unit_two_match(m2), .o_count_q,
    .o_unit_one_this_q, .o_unit_two_this_q, .o_pins_read_q, .o_dir_ignored_q, .o_irq_q
  );
  capture_model u_far
  (
    .i_clk(i_sys_clk), .i_run(run), .i_osc_run(osc_run), .i_mode(mode), .i_fire_one(f1),
    .i_fire_two(f2), .o_pin(pin), .o_osc(osc), .o_mode(mode_o), .o_match_one(m1), .o_match_two(m2)
  );
  // ------
  // tasks
  // ------
  task automatic chk(input logic ok, input string s);
    n_compared++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, s);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic wr(input [1:0] a, input [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  // data stands only in the cycle after the read edge
  task automatic rd(input [1:0] a, input [7:0] e);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata_q === e, "read");
  endtask
  // match one cycle after the request, optional low write beside it
  task automatic ev(input logic two, input logic w);
    @(posedge i_sys_clk);
    f1 <= !two;
    f2 <= two;
    @(posedge i_sys_clk);
    f1 <= 1'b0;
    f2 <= 1'b0;
    i_wr <= w;
    i_addr <= `OFS_COUNT_LOW;
    i_wdata <= 8'h77;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    tk(3);
  endtask
  task automatic complete_run;
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  initial
  begin
    repeat (10000) @(posedge i_sys_clk);
    n_errors++;
    complete_run;
  end
  // ------
  // main sequence
  // ------
  initial
  begin
    {i_srst, i_wr, i_rd, run, osc_run, osc_en, f1, f2} = 8'h80;
    {i_addr, i_wdata} = 10'h000;
    mode = `SPECIAL_EVENT;
    repeat (4) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    rd(`OFS_CONTROL, `CTL_RESET);
    rd(`OFS_COUNT_LOW, 8'h00);
    rd(`OFS_COUNT_HIGH, 8'h00);
    rd(`OFS_FLAGS, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      wr(`OFS_CONTROL, rc[i]);
      wr(`OFS_COUNT_HIGH, 8'h00);
      wr(`OFS_COUNT_LOW, 8'h00);
      tk(40 << rc[i][5:4]);
      chk(o_unit_one_this_q === rc[i][6], "unit one");
      chk(o_unit_two_this_q === (rc[i][6] | rc[i][3]), "unit two");
      chk(o_count_q + 1 >= re[i] && o_count_q <= re[i] + 1, "rate");
    end
    $display("test rows done");
    wr(`OFS_CONTROL, 8'h80);
    wr(`OFS_COUNT_HIGH, 8'h12);
    tk(2);
    chk(o_count_q[15:8] === 8'h00, "high early");
    rd(`OFS_COUNT_HIGH, 8'h12);
    wr(`OFS_COUNT_LOW, 8'h34);
    tk(2);
    chk(o_count_q === 16'h1234, "wide load");
    wr(`OFS_COUNT_HIGH, 8'h56);
    rd(`OFS_COUNT_LOW, 8'h34);
    rd(`OFS_COUNT_HIGH, 8'h12);
    wr(`OFS_CONTROL, 8'h00);
    wr(`OFS_COUNT_HIGH, 8'hA5);
    tk(2);
    chk(o_count_q === 16'hA534, "narrow high");
    rd(`OFS_COUNT_HIGH, 8'hA5);
    $display("test access done");
    wr(`OFS_COUNT_HIGH, 8'hFF);
    wr(`OFS_COUNT_LOW, 8'hFE);
    wr(`OFS_CONTROL, 8'h01);
    tk(30);
    chk(o_irq_q === 1'b0, "irq masked");
    rd(`OFS_FLAGS, 8'h01);
    wr(`OFS_FLAGS, 8'h02);
    wr(`OFS_COUNT_HIGH, 8'hFF);
    wr(`OFS_COUNT_LOW, 8'hFF);
    tk(12);
    chk(o_irq_q === 1'b1, "irq");
    wr(`OFS_FLAGS, 8'h00);
    tk(2);
    chk(o_irq_q === 1'b0, "irq off");
    $display("test overflow done");
    wr(`OFS_CONTROL, 8'h09);
    wr(`OFS_COUNT_HIGH, 8'h40);
    ev(1'b0, 1'b0);
    chk(o_count_q[15:8] === 8'h40, "unit one ignored");
    ev(1'b1, 1'b0);
    chk(o_count_q < 16'h0004, "unit two reset");
    rd(`OFS_FLAGS, 8'h00);
    wr(`OFS_CONTROL, 8'h41);
    wr(`OFS_COUNT_HIGH, 8'h40);
    ev(1'b0, 1'b0);
    chk(o_count_q < 16'h0004, "unit one reset");
    wr(`OFS_COUNT_HIGH, 8'h40);
    ev(1'b1, 1'b1);
    chk(o_count_q[15:8] === 8'h40, "write wins");
    @(posedge i_sys_clk);
    mode <= 4'hA;
    ev(1'b1, 1'b0);
    chk(o_count_q[15:8] === 8'h40, "other mode");
    $display("test events done");
    for (int i = 0; i < 3; i++)
    begin
      @(posedge i_sys_clk);
      osc_en <= (i == 2);
      wr(`OFS_CONTROL, xc[i]);
      wr(`OFS_COUNT_LOW, 8'h00);
      run <= 1'b1;
      osc_run <= (i == 2);
      tk(152);
      // oscillator toggles on the shared pin here: readback must stay zero
      for (int k = 0; k < 8; k++)
      begin
        tk(1);
        if (i == 2)
          chk(o_pins_read_q === 2'b00 && o_dir_ignored_q === 1'b1, "pins live");
      end
      run <= 1'b0;
      osc_run <= 1'b0;
      tk(8);
      chk(o_count_q[7:0] + 3 >= xe[i] && o_count_q[7:0] <= xe[i], "ext rate");
      if (i == 2)
        chk(o_pins_read_q === 2'b00 && o_dir_ignored_q === 1'b1, "pins");
    end
    $display("test external done");
    @(posedge i_sys_clk);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    rd(`OFS_CONTROL, `CTL_RESET);
    chk(o_count_q === `COUNT_RESET, "count reset");
    $display("test second reset done");
    complete_run;
  end
endmodule
